// ---- hw/sas_pkg.sv ----
package sas_pkg;
    // Link and clock timing.
    localparam int CLK_PERIOD_NS  = 5;
    localparam int SCLK_PERIOD_NS = 30;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int CS_GAP_NS      = 30;
    localparam int CS_GAP_CYC     = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Instruction encodings and fields.
    localparam logic [7:0] INST_URA_WR  = 8'h10;
    localparam logic [7:0] INST_URA_RD  = 8'h90;
    localparam int         DIR_BIT      = 7;
    localparam int         SIZE_LO      = 5;
    localparam int         RSVD_BIT     = 4;
    localparam int         LRA_W        = 4;
    localparam int         URA_W        = 3;
    localparam int         ADDR_W       = 7;
    localparam logic [1:0] SZ_ONE       = 2'h0;
    localparam logic [1:0] SZ_STREAM    = 2'h3;

    // Register offsets.
    localparam logic [6:0] REG_STREAM_CTRL = 7'h03;
    localparam logic [6:0] REG_BGCAL       = 7'h10;
    localparam logic [6:0] REG_AUX         = 7'h12;
    localparam logic [6:0] REG_RES_HI      = 7'h1A;
    localparam logic [6:0] REG_RES_MID     = 7'h1B;
    localparam logic [6:0] REG_RES_LO      = 7'h1C;
    localparam logic [6:0] REG_CH_CFG_BASE = 7'h21;
    localparam int         CH_NUM          = 7;
    localparam int         CH_STRIDE       = 2;
    localparam int         REG_NUM         = 128;
    localparam logic [7:0] REG_RST_VAL     = 8'h00;

    // Field positions inside registers.
    localparam int         STRM_KIND_BIT = 7;
    localparam int         STRM_LEN_W    = 7;
    localparam int         CFG_BUF_BIT   = 6;
    localparam int         CFG_GAIN_LO   = 1;
    localparam int         GAIN_W        = 3;
    localparam int         AUX_CLKDET    = 5;
    localparam int         AUX_CLKSEL    = 4;
    localparam logic [7:0] BGCAL_MODE2   = 8'h02;

    // Conversion result range.
    localparam int                       RAW_W       = 28;
    localparam logic signed [RAW_W-1:0]  RAW_POS_LIM = 28'sh07FFFFF;
    localparam logic signed [RAW_W-1:0]  RAW_NEG_LIM = 28'shF800000;
    localparam logic [23:0]              RES_MAX     = 24'h7FFFFF;
    localparam logic [23:0]              RES_MIN     = 24'h800000;
    localparam logic [23:0]              RES_RST_VAL = 24'h000000;

    typedef enum logic [1:0] {
        SAS_D_INSTR  = 2'b00,
        SAS_D_UAB    = 2'b01,
        SAS_D_DATA   = 2'b10,
        SAS_D_IGNORE = 2'b11
    } sas_dev_state_t;

    typedef enum logic [2:0] {
        SAS_H_IDLE   = 3'b000,
        SAS_H_SETUP  = 3'b001,
        SAS_H_GAP    = 3'b010,
        SAS_H_ACCESS = 3'b011,
        SAS_H_END    = 3'b100
    } sas_host_state_t;
endpackage : sas_pkg

// ---- hw/sas_spi_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sas_spi_if;
    logic sclk;
    logic chip_select_n;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    logic miso;

    // The shared data-out wire idles high when the device does not drive it.
    assign miso = miso_oe ? miso_out : 1'b1;

    modport dev (
        input  sclk,
        input  chip_select_n,
        input  mosi,
        output miso_out,
        output miso_oe
    );

    modport host (
        output sclk,
        output chip_select_n,
        output mosi,
        input  miso
    );
endinterface : sas_spi_if
`default_nettype wire

// ---- hw/sas_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sas_host
    import sas_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic              cmd_read_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [1:0]        cmd_size_i,
    input  wire logic [7:0]        cmd_count_i,
    input  wire logic [7:0]        wr_data_i,
    output logic                   wr_take_o,
    output logic [7:0]             rd_data_o,
    output logic                   rd_valid_o,
    output logic                   busy_o,
    sas_spi_if.host                spi
);
    sas_host_state_t   state_ff;
    logic              rst_d_ff;
    logic              sclk_ff;
    logic [1:0]        div_ff;
    logic [2:0]        bit_ff;
    logic              eng_on_ff;
    logic [7:0]        tx_ff;
    logic [7:0]        rx_ff;
    logic              miso_meta_ff;
    logic              miso_sync_ff;
    logic              cs_n_ff;
    logic [3:0]        gap_ff;
    logic [7:0]        left_ff;
    logic              rd_ff;
    logic [1:0]        size_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [URA_W-1:0]  ura_ff;
    logic              ura_ok_ff;
    logic              second_ff;
    logic              tick;
    logic              fall;
    logic              eng_done;
    logic [7:0]        instr;

    assign tick     = (div_ff == 2'(SCLK_HALF_CYC - 1));
    assign fall     = tick && sclk_ff;
    assign eng_done = fall && eng_on_ff && (bit_ff == 3'h7);
    assign instr    = {rd_ff, size_ff, 1'b0, addr_ff[LRA_W-1:0]};

    assign spi.sclk          = sclk_ff;
    assign spi.chip_select_n = cs_n_ff;
    assign spi.mosi          = tx_ff[7];
    assign cmd_ready_o       = (state_ff == SAS_H_IDLE);
    assign busy_o            = (state_ff != SAS_H_IDLE);

    // The link clock also runs in reset, since the device link side has no other clock.
    always_ff @(posedge clk_i) begin
        rst_d_ff <= sys_rst_i;
        if (sys_rst_i && rst_d_ff) begin
            div_ff  <= tick ? 2'h0 : 2'(div_ff + 2'h1);
            sclk_ff <= tick ? ~sclk_ff : sclk_ff;
        end else if (sys_rst_i) begin
            div_ff  <= 2'h0;
            sclk_ff <= 1'b0;
        end else if (eng_on_ff || sclk_ff) begin
            div_ff  <= tick ? 2'h0 : 2'(div_ff + 2'h1);
            sclk_ff <= tick ? ~sclk_ff : sclk_ff;
        end else begin
            div_ff  <= 2'h0;
            sclk_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        miso_meta_ff <= spi.miso;
        miso_sync_ff <= miso_meta_ff;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff   <= SAS_H_IDLE;
            cs_n_ff    <= 1'b1;
            eng_on_ff  <= 1'b0;
            bit_ff     <= 3'h0;
            tx_ff      <= 8'h00;
            rx_ff      <= 8'h00;
            gap_ff     <= 4'h0;
            left_ff    <= 8'h00;
            rd_ff      <= 1'b0;
            size_ff    <= SZ_ONE;
            addr_ff    <= '0;
            ura_ff     <= '0;
            ura_ok_ff  <= 1'b0;
            second_ff  <= 1'b0;
            wr_take_o  <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= 8'h00;
        end else begin
            wr_take_o  <= 1'b0;
            rd_valid_o <= 1'b0;
            if (fall && eng_on_ff) begin
                bit_ff <= 3'(bit_ff + 3'h1);
                tx_ff  <= {tx_ff[6:0], 1'b0};
                rx_ff  <= {rx_ff[6:0], miso_sync_ff};
            end
            case (state_ff)
                SAS_H_IDLE: begin
                    if (cmd_valid_i) begin
                        rd_ff     <= cmd_read_i;
                        size_ff   <= cmd_size_i;
                        addr_ff   <= cmd_addr_i;
                        left_ff   <= (cmd_size_i == SZ_STREAM) ? cmd_count_i
                                                               : 8'({6'h00, cmd_size_i} + 8'h01);
                        cs_n_ff   <= 1'b0;
                        eng_on_ff <= 1'b1;
                        bit_ff    <= 3'h0;
                        second_ff <= 1'b0;
                        if (!ura_ok_ff || ura_ff != cmd_addr_i[ADDR_W-1:LRA_W]) begin
                            state_ff <= SAS_H_SETUP;
                            tx_ff    <= INST_URA_WR;
                        end else begin
                            state_ff <= SAS_H_ACCESS;
                            tx_ff    <= {cmd_read_i, cmd_size_i, 1'b0,
                                         cmd_addr_i[LRA_W-1:0]};
                        end
                    end
                end
                SAS_H_SETUP: begin
                    if (eng_done && !second_ff) begin
                        second_ff <= 1'b1;
                        tx_ff     <= {5'h00, addr_ff[ADDR_W-1:LRA_W]};
                    end else if (eng_done) begin
                        eng_on_ff <= 1'b0;
                        cs_n_ff   <= 1'b1;
                        ura_ff    <= addr_ff[ADDR_W-1:LRA_W];
                        ura_ok_ff <= 1'b1;
                        gap_ff    <= 4'(CS_GAP_CYC);
                        state_ff  <= SAS_H_GAP;
                    end
                end
                SAS_H_GAP: begin
                    if (gap_ff != 4'h0) begin
                        gap_ff <= 4'(gap_ff - 4'h1);
                    end else begin
                        cs_n_ff   <= 1'b0;
                        eng_on_ff <= 1'b1;
                        bit_ff    <= 3'h0;
                        second_ff <= 1'b0;
                        tx_ff     <= instr;
                        state_ff  <= SAS_H_ACCESS;
                    end
                end
                SAS_H_ACCESS: begin
                    if (eng_done) begin
                        if (second_ff) begin
                            rd_data_o  <= {rx_ff[6:0], miso_sync_ff};
                            rd_valid_o <= rd_ff;
                            left_ff    <= 8'(left_ff - 8'h01);
                        end
                        second_ff <= 1'b1;
                        if (second_ff && left_ff == 8'h01) begin
                            eng_on_ff <= 1'b0;
                            cs_n_ff   <= 1'b1;
                            gap_ff    <= 4'(CS_GAP_CYC);
                            state_ff  <= SAS_H_END;
                        end else begin
                            tx_ff     <= rd_ff ? 8'h00 : wr_data_i;
                            wr_take_o <= !rd_ff;
                        end
                    end
                end
                SAS_H_END: begin
                    if (gap_ff != 4'h0) begin
                        gap_ff <= 4'(gap_ff - 4'h1);
                    end else begin
                        state_ff <= SAS_H_IDLE;
                    end
                end
                default: begin
                    state_ff <= SAS_H_IDLE;
                end
            endcase
        end
    end
endmodule : sas_host
`default_nettype wire

// ---- hw/sas_device.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Result is 24-bit two's complement, three bytes.
// - Over range clamps to largest positive or negative.
// - Result bytes sit at 0x1A, 0x1B, 0x1C.
// - Upper-address setup starts with 0x10 or 0x90.
// - Upper byte carries address in bits 2:0.
// - Host may skip setup if address unchanged.
// - Instruction: direction bit7, size 6:5, address 3:0.
// - Size codes one, two, three bytes or stream.
// - Normal streaming steps to next higher address.
// - Reset selects normal streaming.
// - Stream-kind bit at 0x03 selects controlled streaming.
// - Window length field holds register count minus one.
// - Chip select released between and after transactions.
// - Gain field zero selects unity gain.
// - Buffer-control bit one bypasses input buffer.
// - Writing 0x2 selects background calibration mode two.
// - Detect bypass one, source zero: internal clock.
// - Bytes shifted MSB first within one chip select.
module sas_device
    import sas_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic signed [RAW_W-1:0] raw_sample_i,
    input  wire logic                    raw_valid_i,
    output logic [CH_NUM*GAIN_W-1:0]     ch_gain_o,
    output logic [CH_NUM-1:0]            ch_buf_bypass_o,
    output logic                         bgcal_mode_two_o,
    output logic                         internal_clock_o,
    sas_spi_if.dev                       spi
);
    localparam int CFG_W = CH_NUM * GAIN_W + CH_NUM + 2;

    // Conversion result, device clock side.
    logic [23:0]       result_ff;
    logic [23:0]       nxt_result;
    logic              res_tgl_ff;

    // Link clock side, then the configuration path back to the device clock.
    logic              rst_meta_ff;
    logic              rst_sync_ff;
    logic              tgl_meta_ff;
    logic              tgl_sync_ff;
    logic              tgl_seen_ff;
    logic [23:0]       res_hold_ff;
    logic [7:0]        regs_ff [REG_NUM];
    logic [URA_W-1:0]  ura_ff;
    sas_dev_state_t    state_ff;
    logic [2:0]        bit_ff;
    logic [6:0]        sh_ff;
    logic [7:0]        tx_ff;
    logic              tx_en_ff;
    logic              rd_ff;
    logic              stream_ff;
    logic [1:0]        left_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] win_start_ff;
    logic              miso_ff;
    logic              oe_ff;
    logic              byte_done;
    logic [7:0]        rx_byte;
    logic [ADDR_W-1:0] instr_addr;
    logic [ADDR_W-1:0] nxt_addr;
    logic [ADDR_W-1:0] win_last;
    logic              ctrl_stream;
    logic              wr_en;
    logic [CFG_W-1:0]  cfg_link;
    logic [CFG_W-1:0]  cfg_meta_ff;
    logic [CFG_W-1:0]  cfg_sync_ff;
    logic [CFG_W-1:0]  cfg_last_ff;
    logic [CFG_W-1:0]  cfg_out_ff;

    // Clamp the wide raw sample into the 24-bit result range.
    always_comb begin
        if (raw_sample_i > RAW_POS_LIM) begin
            nxt_result = RES_MAX;
        end else if (raw_sample_i < RAW_NEG_LIM) begin
            nxt_result = RES_MIN;
        end else begin
            nxt_result = raw_sample_i[23:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            result_ff  <= RES_RST_VAL;
            res_tgl_ff <= 1'b0;
        end else if (raw_valid_i) begin
            result_ff  <= nxt_result;
            res_tgl_ff <= ~res_tgl_ff;
        end
    end

    // Reset and the result toggle cross into the link domain. The result word
    // is copied only after the toggle has settled, so result_ff is stable then.
    always_ff @(posedge spi.sclk) begin
        rst_meta_ff <= sys_rst_i;
        rst_sync_ff <= rst_meta_ff;
        tgl_meta_ff <= res_tgl_ff;
        tgl_sync_ff <= tgl_meta_ff;
    end

    always_ff @(posedge spi.sclk) begin
        if (rst_sync_ff) begin
            tgl_seen_ff <= 1'b0;
            res_hold_ff <= RES_RST_VAL;
        end else if (tgl_sync_ff != tgl_seen_ff) begin
            tgl_seen_ff <= tgl_sync_ff;
            res_hold_ff <= result_ff;
        end
    end

    function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
        if (a == REG_RES_HI) begin
            read_reg = res_hold_ff[23:16];
        end else if (a == REG_RES_MID) begin
            read_reg = res_hold_ff[15:8];
        end else if (a == REG_RES_LO) begin
            read_reg = res_hold_ff[7:0];
        end else begin
            read_reg = regs_ff[a];
        end
    endfunction : read_reg

    assign byte_done   = (bit_ff == 3'h7);
    assign rx_byte     = {sh_ff, spi.mosi};
    assign instr_addr  = {ura_ff, rx_byte[LRA_W-1:0]};
    assign ctrl_stream = regs_ff[REG_STREAM_CTRL][STRM_KIND_BIT];
    assign win_last    = ADDR_W'(win_start_ff + regs_ff[REG_STREAM_CTRL][STRM_LEN_W-1:0]);

    // Controlled streaming wraps at the window end; otherwise step upward.
    always_comb begin
        if (stream_ff && ctrl_stream && addr_ff == win_last) begin
            nxt_addr = win_start_ff;
        end else begin
            nxt_addr = ADDR_W'(addr_ff + 7'h01);
        end
    end

    assign wr_en = (state_ff == SAS_D_DATA) && !rd_ff && byte_done
                   && addr_ff != REG_RES_HI && addr_ff != REG_RES_MID
                   && addr_ff != REG_RES_LO;

    // Register file and retained upper address survive chip select release.
    always_ff @(posedge spi.sclk) begin
        if (rst_sync_ff) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_ff[i] <= REG_RST_VAL;
            end
            ura_ff <= '0;
        end else begin
            if (wr_en) begin
                regs_ff[addr_ff] <= rx_byte;
            end
            if (state_ff == SAS_D_UAB && !rd_ff && byte_done) begin
                ura_ff <= rx_byte[URA_W-1:0];
            end
        end
    end

    // Frame logic restarts whenever chip select is released.
    always_ff @(posedge spi.sclk or posedge spi.chip_select_n) begin
        if (spi.chip_select_n) begin
            state_ff     <= SAS_D_INSTR;
            bit_ff       <= 3'h0;
            sh_ff        <= 7'h00;
            tx_ff        <= 8'h00;
            tx_en_ff     <= 1'b0;
            rd_ff        <= 1'b0;
            stream_ff    <= 1'b0;
            left_ff      <= 2'h0;
            addr_ff      <= '0;
            win_start_ff <= '0;
        end else begin
            bit_ff <= 3'(bit_ff + 3'h1);
            sh_ff  <= rx_byte[6:0];
            tx_ff  <= {tx_ff[6:0], 1'b0};
            if (byte_done) begin
                case (state_ff)
                    SAS_D_INSTR: begin
                        if (rx_byte == INST_URA_WR) begin
                            state_ff <= SAS_D_UAB;
                            rd_ff    <= 1'b0;
                        end else if (rx_byte == INST_URA_RD) begin
                            state_ff <= SAS_D_UAB;
                            rd_ff    <= 1'b1;
                            tx_en_ff <= 1'b1;
                            tx_ff    <= {5'h00, ura_ff};
                        end else if (!rx_byte[RSVD_BIT]) begin
                            state_ff     <= SAS_D_DATA;
                            rd_ff        <= rx_byte[DIR_BIT];
                            addr_ff      <= instr_addr;
                            win_start_ff <= instr_addr;
                            stream_ff    <= (rx_byte[6:SIZE_LO] == SZ_STREAM);
                            left_ff      <= rx_byte[6:SIZE_LO];
                            tx_en_ff     <= rx_byte[DIR_BIT];
                            tx_ff        <= read_reg(instr_addr);
                        end else begin
                            state_ff <= SAS_D_IGNORE;
                        end
                    end
                    SAS_D_UAB: begin
                        // A new frame is needed for the data access.
                        state_ff <= SAS_D_IGNORE;
                        tx_en_ff <= 1'b0;
                    end
                    SAS_D_DATA: begin
                        addr_ff <= nxt_addr;
                        tx_ff   <= read_reg(nxt_addr);
                        if (!stream_ff && left_ff == SZ_ONE) begin
                            state_ff <= SAS_D_IGNORE;
                            tx_en_ff <= 1'b0;
                        end else if (!stream_ff) begin
                            left_ff <= 2'(left_ff - 2'h1);
                        end
                    end
                    default: begin
                        state_ff <= SAS_D_IGNORE;
                    end
                endcase
            end
        end
    end

    // Data out changes on the falling edge so the host samples it stable.
    always_ff @(negedge spi.sclk or posedge spi.chip_select_n) begin
        if (spi.chip_select_n) begin
            miso_ff <= 1'b1;
            oe_ff   <= 1'b0;
        end else begin
            miso_ff <= tx_ff[7];
            oe_ff   <= tx_en_ff;
        end
    end

    assign spi.miso_out = miso_ff;
    assign spi.miso_oe  = oe_ff;

    // Configuration decode; a word is taken once two samples agree.
    always_comb begin
        cfg_link = '0;
        for (int c = 0; c < CH_NUM; c++) begin
            cfg_link[c*GAIN_W +: GAIN_W] =
                regs_ff[REG_CH_CFG_BASE + CH_STRIDE*c][CFG_GAIN_LO +: GAIN_W];
            cfg_link[CH_NUM*GAIN_W + c] =
                regs_ff[REG_CH_CFG_BASE + CH_STRIDE*c][CFG_BUF_BIT];
        end
        cfg_link[CFG_W-2] = (regs_ff[REG_BGCAL] == BGCAL_MODE2);
        cfg_link[CFG_W-1] = regs_ff[REG_AUX][AUX_CLKDET]
                            && !regs_ff[REG_AUX][AUX_CLKSEL];
    end

    always_ff @(posedge clk_i) begin
        cfg_meta_ff <= cfg_link;
        cfg_sync_ff <= cfg_meta_ff;
        cfg_last_ff <= cfg_sync_ff;
        if (cfg_sync_ff == cfg_last_ff) begin
            cfg_out_ff <= cfg_sync_ff;
        end
    end

    assign ch_gain_o        = cfg_out_ff[CH_NUM*GAIN_W-1:0];
    assign ch_buf_bypass_o  = cfg_out_ff[CH_NUM*GAIN_W +: CH_NUM];
    assign bgcal_mode_two_o = cfg_out_ff[CFG_W-2];
    assign internal_clock_o = cfg_out_ff[CFG_W-1];
endmodule : sas_device
`default_nettype wire

// ---- tb/sas_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module sas_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic miso
);
    logic [7:0] rise_cnt_ff;

    // Link clock rises in this frame.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || chip_select_n) begin
            rise_cnt_ff <= 8'h00;
        end else if ($rose(sclk)) begin
            rise_cnt_ff <= rise_cnt_ff + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_gap; $rose(chip_select_n) |-> chip_select_n [*6]; endproperty
    a_gap: assert property (p_gap) else $error("chip select gap too short");
    property p_idle; chip_select_n && !sclk |=> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("link clock runs between frames");
    property p_high; $rose(sclk) && !chip_select_n |-> sclk [*3] ##1 !sclk; endproperty
    a_high: assert property (p_high) else $error("link clock high phase wrong");
    property p_mosi; !chip_select_n && sclk && $past(sclk) |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("host data moved while clock high");
    property p_fall; miso_oe && $changed(miso_out) |-> !sclk; endproperty
    a_fall: assert property (p_fall) else $error("device data moved while clock high");
    property p_off; chip_select_n |=> !miso_oe && miso; endproperty
    a_off: assert property (p_off) else $error("device drives outside a frame");
    property p_bytes; $rose(chip_select_n) |-> rise_cnt_ff[2:0] == 3'h0; endproperty
    a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
    property p_turn; $rose(miso_oe) |-> rise_cnt_ff == 8'h08 && !sclk; endproperty
    a_turn: assert property (p_turn) else $error("read data not after instruction");
endmodule : sas_properties
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sas_pkg::*;
;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_read_i = 1'b0;
    logic raw_valid_i = 1'b0, cmd_ready_o, wr_take_o, rd_valid_o, busy_o;
    logic bgcal_mode_two_o, internal_clock_o;
    logic [ADDR_W-1:0] cmd_addr_i = 7'h00, cfg_a[4];
    logic [1:0] cmd_size_i = 2'h0, cfg_e[4];
    logic [7:0] cmd_count_i = 8'h00, wr_data_i = 8'h00, rd_data_o, b[13], wq[$], exp_q[$], cfg_d[4];
    logic signed [RAW_W-1:0] raw_sample_i = 28'sh0000000, raw_tab[4];
    logic [CH_NUM*GAIN_W-1:0] ch_gain_o;
    logic [CH_NUM-1:0] ch_buf_bypass_o;
    logic [23:0] res_exp[4], r;
    int num_errors = 0, compares = 0;

    sas_spi_if spi ();
    sas_host i_sas_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_addr_i(cmd_addr_i),
        .cmd_size_i(cmd_size_i), .cmd_count_i(cmd_count_i), .wr_data_i(wr_data_i),
        .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .busy_o(busy_o), .spi(spi));
    sas_device i_sas_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .raw_sample_i(raw_sample_i),
        .raw_valid_i(raw_valid_i), .ch_gain_o(ch_gain_o), .ch_buf_bypass_o(ch_buf_bypass_o),
        .bgcal_mode_two_o(bgcal_mode_two_o), .internal_clock_o(internal_clock_o), .spi(spi));
    sas_properties i_sas_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk(spi.sclk),
        .chip_select_n(spi.chip_select_n), .mosi(spi.mosi), .miso_out(spi.miso_out),
        .miso_oe(spi.miso_oe), .miso(spi.miso));

    always #(CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic xfer(input logic rd, input logic [6:0] a, input logic [1:0] sz,
                        input logic [7:0] n);
        int k;
        @(posedge clk_i) #1;
        {cmd_read_i, cmd_addr_i, cmd_size_i, cmd_count_i} = {rd, a, sz, n};
        wr_data_i = wq.size() > 0 ? wq[0] : 8'h00;
        cmd_valid_i = 1'b1;
        for (k = 0; cmd_ready_o !== 1'b1 && k < 100; k++) @(posedge clk_i) #1;
        if (k == 100) num_errors++;
        @(posedge clk_i) #1;
        cmd_valid_i = 1'b0;
        for (k = 0; busy_o === 1'b1 && k < 2000; k++) @(posedge clk_i) #1;
        if (k == 2000) num_errors++;
        repeat (4) @(posedge clk_i);
    endtask : xfer

    // Show the next write byte once the host has taken this one.
    always @(posedge clk_i) begin
        if (wr_take_o === 1'b1 && wq.size() > 0) begin
            #1;
            void'(wq.pop_front());
            wr_data_i = wq.size() > 0 ? wq[0] : 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (rd_valid_o === 1'b1) begin
            check("rd_data_o", {16'h0000, rd_data_o}, exp_q.size() > 0 ?
                  {16'h0000, exp_q.pop_front()} : 24'hXXXXXX);
        end
    end

    initial begin
        #(CLK_PERIOD_NS * 20000);
        num_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(93575));
        // The device link side sees reset only on link clock edges.
        repeat (40) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (8) @(posedge clk_i);
        check("reset gain", {3'h0, ch_gain_o}, 24'h000000);
        check("reset flags", 24'({ch_buf_bypass_o, bgcal_mode_two_o, internal_clock_o}), 24'h000000);
        foreach (b[i]) begin
            b[i] = 8'($urandom);
            wq.push_back(b[i]);
        end
        xfer(1'b0, REG_CH_CFG_BASE, SZ_STREAM, 8'h0D);
        for (int c = 0; c < CH_NUM; c++) begin
            check("gain", 24'(ch_gain_o[c*GAIN_W +: GAIN_W]), 24'(b[2*c][CFG_GAIN_LO +: GAIN_W]));
            check("bypass", 24'(ch_buf_bypass_o[c]), 24'(b[2*c][CFG_BUF_BIT]));
        end
        foreach (b[i]) exp_q.push_back(b[i]);
        xfer(1'b1, REG_CH_CFG_BASE, SZ_STREAM, 8'h0D);
        cfg_a = '{REG_BGCAL, REG_BGCAL, REG_AUX, REG_AUX};
        cfg_d = '{BGCAL_MODE2, 8'h03, 8'h20, 8'h30};
        cfg_e = '{2'h2, 2'h0, 2'h1, 2'h0};
        foreach (cfg_a[i]) begin
            wq.push_back(cfg_d[i]);
            xfer(1'b0, cfg_a[i], SZ_ONE, 8'h01);
            check("bgcal/clock", 24'({bgcal_mode_two_o, internal_clock_o}), 24'(cfg_e[i]));
        end
        r = 24'($urandom);
        raw_tab = '{28'sh0800000, 28'shF7FFFFF, RAW_NEG_LIM, {{4{r[23]}}, r}};
        res_exp = '{RES_MAX, RES_MIN, RES_MIN, r};
        foreach (raw_tab[i]) begin
            @(posedge clk_i) #1;
            raw_sample_i = raw_tab[i];
            raw_valid_i = 1'b1;
            @(posedge clk_i) #1;
            raw_valid_i = 1'b0;
            for (int j = 2; j >= 0; j--) exp_q.push_back(res_exp[i][8*j +: 8]);
            xfer(1'b1, REG_RES_HI, 2'h2, 8'h03);
        end
        exp_q.push_back(r[15:8]);
        exp_q.push_back(r[7:0]);
        xfer(1'b1, REG_RES_MID, 2'h1, 8'h02);
        wq.push_back(8'h55);
        xfer(1'b0, REG_RES_HI, SZ_ONE, 8'h01);
        wq.push_back(8'h82);
        xfer(1'b0, REG_STREAM_CTRL, SZ_ONE, 8'h01);
        for (int j = 0; j < 7; j++) exp_q.push_back(r[8*(2-j%3) +: 8]);
        xfer(1'b1, REG_RES_HI, SZ_STREAM, 8'h07);
        wq.push_back(8'h00);
        xfer(1'b0, REG_STREAM_CTRL, SZ_ONE, 8'h01);
        for (int j = 0; j < 3; j++) exp_q.push_back(r[8*(2-j) +: 8]);
        exp_q.push_back(8'h00);
        xfer(1'b1, REG_RES_HI, SZ_STREAM, 8'h04);
        check("unread", 24'(exp_q.size()), 24'h000000);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
